/* File: dv/fbfr_bridge_chk.sv */
// Checker of bridge switch, pin and fault timing
`timescale 1ns/1ps
module fbfr_bridge_chk
  import fbfr_pkg::*;
#(
  parameter int unsigned RETRY_CNT = RETRY_CYCLES,
  parameter int unsigned DEAD_CNT  = DEAD_CYCLES,
  parameter int unsigned WAKE_CNT  = WAKE_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic phase_i,
  input wire logic enable_i,
  input wire logic slow_decay_i,
  input wire logic sleep_n_i,
  input wire logic short_det_i,
  input wire logic zero_current_i,
  input wire logic bridge_a_src_o,
  input wire logic bridge_a_snk_o,
  input wire logic bridge_b_src_o,
  input wire logic bridge_b_snk_o,
  input wire logic bridge_out_a_oe_n_o,
  input wire logic bridge_out_a_o,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic        any_on;
  int unsigned low_cnt;
  assign any_on = bridge_a_src_o | bridge_a_snk_o | bridge_b_src_o | bridge_b_snk_o;
  // Length of the present fault flag assertion
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) low_cnt <= 0;
    else low_cnt <= fault_flag_n_oe_n_o ? 0 : low_cnt + 1;
  end
  shoot_thru_a: assert property (!(bridge_a_src_o && bridge_a_snk_o) && !(bridge_b_src_o && bridge_b_snk_o))
    else $error("leg source and sink on together");
  dead_time_a: assert property ($fell(bridge_a_snk_o) |-> !bridge_a_src_o [*3])
    else $error("source on inside dead time");
  sleep_float_a: assert property (!sleep_n_i [*5] |-> !any_on && bridge_out_a_oe_n_o)
    else $error("bridge driven while asleep");
  pin_level_a: assert property (bridge_out_a_oe_n_o == !(bridge_a_src_o || bridge_a_snk_o)
    && bridge_out_a_o == bridge_a_src_o && !fault_flag_n_o) else $error("pin level or enable wrong");
  fault_off_a: assert property ($fell(fault_flag_n_oe_n_o) |=> !any_on [*8])
    else $error("switches on after fault");
  short_trip_a: assert property ((short_det_i && sleep_n_i) [*3] |-> ##[0:2] !fault_flag_n_oe_n_o)
    else $error("short not flagged");
  retry_len_a: assert property ($rose(fault_flag_n_oe_n_o) |-> low_cnt >= RETRY_CNT - 1)
    else $error("fault interval too short");
  retry_hold_a: assert property ((!fault_flag_n_oe_n_o && short_det_i) [*3] |=> !fault_flag_n_oe_n_o [*8])
    else $error("flag released with short present");
  drive_fwd_a: assert property ((sleep_n_i && enable_i && phase_i && !short_det_i) [*8] ##0 fault_flag_n_oe_n_o
    |-> bridge_a_src_o && bridge_b_snk_o && !bridge_a_snk_o && !bridge_b_src_o) else $error("forward drive wrong");
  brake_sinks_a: assert property ((sleep_n_i && !enable_i && slow_decay_i) [*8] ##0 fault_flag_n_oe_n_o
    |-> bridge_a_snk_o && bridge_b_snk_o && !bridge_a_src_o && !bridge_b_src_o) else $error("brake wrong");
  zero_float_a: assert property ((sleep_n_i && !enable_i && !slow_decay_i && zero_current_i) [*5] |-> !any_on)
    else $error("switches on at zero current");
endmodule
bind fbfr_bridge fbfr_bridge_chk #(.RETRY_CNT(RETRY_CNT), .DEAD_CNT(DEAD_CNT), .WAKE_CNT(WAKE_CNT)) i_chk (.*);

/* File: dv/fbfr_motor.sv */
// Motor load model: winding current and short detection
`timescale 1ns/1ps
module fbfr_motor
  import fbfr_pkg::*;
(
  input  wire logic            clk_i,
  input  wire fbfr_bridge_type sw_i,
  input  wire logic            short_cmd_i,
  output logic                 short_det_o,
  output logic                 zero_current_o
);
  int cur = 0;
  // Current ramps on a diagonal, bleeds off when no source is on
  always @(posedge clk_i) begin
    if (sw_i.leg_a.src && sw_i.leg_b.snk && cur < 40) cur <= cur + 1;
    else if (sw_i.leg_b.src && sw_i.leg_a.snk && cur > -40) cur <= cur - 1;
    else if (!(sw_i.leg_a.src || sw_i.leg_b.src) && cur != 0) cur <= cur > 0 ? cur - 1 : cur + 1;
  end
  // Slack band: the bridge needs a few cycles to float
  assign zero_current_o = cur < 4 && cur > -4;
  // A short shows only while some switch conducts
  assign short_det_o = short_cmd_i && (|sw_i);
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the bridge fault and retry logic
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
module testbench;
  import fbfr_pkg::*;
  localparam int unsigned RETRY = 50;
  logic            sys_clk_i, rst_i, short_cmd, short_det, zero, wake, flag, flag_oe;
  logic            a_src, a_snk, b_src, b_snk, oe_a, out_a, oe_b, out_b;
  fbfr_ctrl_type   ctl;
  fbfr_bridge_type sw;
  int              n_errors, comparisons, cycles;
  assign sw = '{leg_a: '{a_src, a_snk}, leg_b: '{b_src, b_snk}};
  fbfr_bridge #(.RETRY_CNT(RETRY), .DEAD_CNT(2), .WAKE_CNT(20)) i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .phase_i(ctl.phase), .enable_i(ctl.enable), .slow_decay_i(ctl.slow_decay), .sleep_n_i(ctl.awake),
    .short_det_i(short_det), .zero_current_i(zero), .bridge_a_src_o(a_src), .bridge_a_snk_o(a_snk),
    .bridge_b_src_o(b_src), .bridge_b_snk_o(b_snk), .bridge_out_a_oe_n_o(oe_a), .bridge_out_a_o(out_a),
    .bridge_out_b_oe_n_o(oe_b), .bridge_out_b_o(out_b), .fault_flag_n_o(flag), .fault_flag_n_oe_n_o(flag_oe),
    .wake_ready_o(wake));
  fbfr_motor i_load (.clk_i(sys_clk_i), .sw_i(sw), .short_cmd_i(short_cmd), .short_det_o(short_det),
    .zero_current_o(zero));
  // Clock and hang guard
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Apply controls at an edge, wait n edges, judge the switches
  task automatic step(input logic [3:0] c, input int n, input logic [3:0] e, input string s);
    @(posedge sys_clk_i);
    ctl <= c;
    repeat (n) @(posedge sys_clk_i);
    #1;
    `CHK(s, e, sw)
  endtask
  task automatic t_sleep();
    step(4'hC, 8, 4'h0, "sleep");
    `CHK("sleep oe", 2'h3, {oe_a, oe_b})
    `CHK("asleep wake", 1'b0, wake)
    step(4'h3, 10, 4'h5, "brake");
    `CHK("wake early", 1'b0, wake)
    repeat (20) @(posedge sys_clk_i);
    #1;
    `CHK("wake", 1'b1, wake)
  endtask
  task automatic t_drive();
    step(4'hD, 8, 4'h9, "fwd");
    `CHK("fwd pins", 4'h4, {oe_a, out_a, oe_b, out_b})
    step(4'h5, 5, 4'h0, "dead");
    step(4'h5, 5, 4'h6, "rev");
  endtask
  task automatic t_fast();
    step(4'hD, 45, 4'h9, "fwd");
    step(4'h9, 8, 4'h6, "fast fwd");
    step(4'h9, 50, 4'h0, "zero fwd");
    step(4'h5, 45, 4'h6, "rev");
    step(4'h1, 8, 4'h9, "fast rev");
    step(4'h1, 50, 4'h0, "zero rev");
  endtask
  task automatic t_short();
    int i;
    step(4'hD, 10, 4'h9, "pre");
    @(posedge sys_clk_i);
    short_cmd <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    #1;
    `CHK("trip", 5'h00, {flag_oe, sw})
    // Retry turns on into the same short
    // Look off the edge so the registered switches have settled
    for (i = 0; i < 2 * RETRY && sw == 4'h0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    #1;
    `CHK("retry on", 2'b10, {sw != 4'h0, flag_oe})
    repeat (10) @(posedge sys_clk_i);
    #1;
    `CHK("again", 5'h00, {flag_oe, sw})
    @(posedge sys_clk_i);
    short_cmd <= 1'b0;
    for (i = 0; i < 3 * RETRY && flag_oe !== 1'b1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    @(posedge sys_clk_i);
    #1;
    `CHK("release", 5'h19, {flag_oe, sw})
  endtask
  initial begin
    rst_i = 1'b1;
    ctl = 4'h0;
    short_cmd = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_sleep();
    t_drive();
    t_fast();
    t_short();
    conclude();
  end
endmodule

/* File: inc/fbfr_pkg.sv */
// Package with timing constants, types and states for the bridge fault/retry logic
package fbfr_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned DEAD_TIME_NS      = 500;
  localparam int unsigned RETRY_INTERVAL_US = 1200;
  localparam int unsigned WAKE_SETTLE_US    = 1000;
  // Dead time is a least time: round up
  localparam int unsigned DEAD_CYCLES  = (DEAD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // Retry interval is a nominal period: whole cycles
  localparam int unsigned RETRY_CYCLES = RETRY_INTERVAL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_CYCLES  = WAKE_SETTLE_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // Types
  // ****************************************
  // Switch commands of one bridge leg
  typedef struct packed {
    logic src;
    logic snk;
  } fbfr_leg_type;

  // Switch commands of the whole bridge
  typedef struct packed {
    fbfr_leg_type leg_a;
    fbfr_leg_type leg_b;
  } fbfr_bridge_type;

  // Control inputs from the PWM source
  typedef struct packed {
    logic phase;
    logic enable;
    logic slow_decay;
    logic awake;
  } fbfr_ctrl_type;

  localparam fbfr_bridge_type BRIDGE_OFF = '{leg_a: '{1'b0, 1'b0}, leg_b: '{1'b0, 1'b0}};

  typedef enum logic [1:0] {
    FLT_RUN   = 2'b00,
    FLT_OFF   = 2'b01,
    FLT_RETRY = 2'b10
  } fbfr_flt_state_type;

endpackage

/* File: rtl/fbfr_bridge.sv */
// Top level: input synchronisers, bridge truth table, short retry and fault flag
`timescale 1ns/1ps
// How it works
// - A detected short turns every switch off, pulls the fault flag low and starts the retry timer.
// - When the retry interval ends the bridge follows the inputs again and tries to turn on.
// - A short still present on the retry turn-on repeats the off, flag low and full interval.
// - No short after the interval releases the fault flag and normal running resumes.
// - Source and sink of one leg are never on together and a dead time separates them.
// - The rectifying switch in a decay path turns on only after the dead time.
// - Drive turns on one source and the opposite sink in the commanded direction.
// - Fast decay turns on the opposite diagonal to drive.
// - In fast decay a near-zero current indication turns all switches off.
// - Slow decay turns on both sinks and keeps both sources off.
// - Awake and enabled, phase high gives A high B low and phase low the reverse.
// - Enable low with slow decay gives both low, else outputs opposite to phase until near-zero current floats both.
// - Sleep low floats both outputs; the controller waits after waking before PWM.
module fbfr_bridge
  import fbfr_pkg::*;
#(
  parameter int unsigned RETRY_CNT = RETRY_CYCLES,
  parameter int unsigned DEAD_CNT  = DEAD_CYCLES,
  parameter int unsigned WAKE_CNT  = WAKE_CYCLES
) (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  input  wire logic   phase_i,
  input  wire logic   enable_i,
  input  wire logic   slow_decay_i,
  input  wire logic   sleep_n_i,
  input  wire logic   short_det_i,
  input  wire logic   zero_current_i,
  output logic        bridge_a_src_o,
  output logic        bridge_a_snk_o,
  output logic        bridge_b_src_o,
  output logic        bridge_b_snk_o,
  output logic        bridge_out_a_oe_n_o,
  output logic        bridge_out_a_o,
  output logic        bridge_out_b_oe_n_o,
  output logic        bridge_out_b_o,
  output logic        fault_flag_n_o,
  output logic        fault_flag_n_oe_n_o,
  output logic        wake_ready_o
);

  initial begin
    if (RETRY_CNT < 2 || RETRY_CNT > 2**24 - 1 || WAKE_CNT < 1 || WAKE_CNT > 2**24 - 1) begin
      $error("fbfr_bridge: counter parameter out of range");
    end
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int unsigned NSYNC = 6;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg, sync2_reg;
  assign raw_in = {phase_i, enable_i, slow_decay_i, sleep_n_i, short_det_i, zero_current_i};

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  fbfr_ctrl_type ctrl;
  logic          short_s;
  logic          zero_s;
  assign ctrl    = fbfr_ctrl_type'(sync2_reg[5:2]);
  assign short_s = sync2_reg[1];
  assign zero_s  = sync2_reg[0];

  // ****************************************
  // Fault retry state machine
  // ****************************************
  fbfr_flt_state_type st_reg, st_next;
  logic [23:0]        tmr_reg, tmr_next;
  logic               flag_reg, flag_next;  // High while fault flag is pulled low
  fbfr_bridge_type    want;                 // Commanded switch pattern

  always_comb begin
    st_next   = st_reg;
    tmr_next  = tmr_reg;
    flag_next = flag_reg;
    unique case (st_reg)
      FLT_RUN: begin
        if (short_s && ctrl.awake) begin
          st_next   = FLT_OFF;
          flag_next = 1'b1;
          tmr_next  = RETRY_CNT[23:0] - 24'h000001;
        end
      end
      FLT_OFF: begin
        if (tmr_reg == 24'h000000) begin
          st_next  = FLT_RETRY;
          tmr_next = DEAD_CNT[23:0] + 24'h000002;
        end else begin
          tmr_next = tmr_reg - 24'h000001;
        end
      end
      FLT_RETRY: begin
        // Short sampled every cycle until the retry turn-on has had time to settle
        if (short_s) begin
          st_next  = FLT_OFF;
          tmr_next = RETRY_CNT[23:0] - 24'h000001;
        // Judged on the command, not the legs: the legs are still off on entry
        end else if (tmr_reg == 24'h000000 || want == BRIDGE_OFF) begin
          st_next   = FLT_RUN;
          flag_next = 1'b0;
        end else begin
          tmr_next = tmr_reg - 24'h000001;
        end
      end
      default: begin
        st_next = FLT_OFF;
        tmr_next = RETRY_CNT[23:0] - 24'h000001;
        flag_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg   <= FLT_RUN;
      tmr_reg  <= 24'h000000;
      flag_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      flag_reg <= flag_next;
    end
  end

  // ****************************************
  // Wake settle indication
  // ****************************************
  logic [23:0] wake_reg, wake_next;

  // host should wait for this before PWM
  always_comb begin
    wake_next = wake_reg;
    if (!ctrl.awake) begin
      wake_next = WAKE_CNT[23:0];
    end else if (wake_reg != 24'h000000) begin
      wake_next = wake_reg - 24'h000001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_reg <= WAKE_CNT[23:0];
    end else begin
      wake_reg <= wake_next;
    end
  end

  // ****************************************
  // Bridge truth table
  // ****************************************
  always_comb begin
    want = BRIDGE_OFF;
    if (!ctrl.awake || st_reg == FLT_OFF) begin
      want = BRIDGE_OFF;
    end else if (ctrl.enable) begin
      want.leg_a.src = ctrl.phase;
      want.leg_b.snk = ctrl.phase;
      want.leg_b.src = !ctrl.phase;
      want.leg_a.snk = !ctrl.phase;
    end else if (ctrl.slow_decay) begin
      want.leg_a.snk = 1'b1;
      want.leg_b.snk = 1'b1;
    end else if (!zero_s) begin
      want.leg_a.src = !ctrl.phase;
      want.leg_b.snk = !ctrl.phase;
      want.leg_b.src = ctrl.phase;
      want.leg_a.snk = ctrl.phase;
    end
  end

  fbfr_leg_type leg_a, leg_b;

  fbfr_leg #(
    .DEAD_CNT (DEAD_CNT)
  ) u_leg_a (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .want_i    (want.leg_a),
    .leg_o     (leg_a)
  );

  fbfr_leg #(
    .DEAD_CNT (DEAD_CNT)
  ) u_leg_b (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .want_i    (want.leg_b),
    .leg_o     (leg_b)
  );

  // ****************************************
  // Outputs
  // ****************************************
  // Leg level follows registered switch commands; floats when both off
  assign bridge_a_src_o      = leg_a.src;
  assign bridge_a_snk_o      = leg_a.snk;
  assign bridge_b_src_o      = leg_b.src;
  assign bridge_b_snk_o      = leg_b.snk;
  assign bridge_out_a_o      = leg_a.src;
  assign bridge_out_a_oe_n_o = !(leg_a.src | leg_a.snk);
  assign bridge_out_b_o      = leg_b.src;
  assign bridge_out_b_oe_n_o = !(leg_b.src | leg_b.snk);
  // Open drain: only ever drives low
  assign fault_flag_n_o      = 1'b0;
  assign fault_flag_n_oe_n_o = !flag_reg;
  assign wake_ready_o        = (wake_reg == 24'h000000);

endmodule

/* File: rtl/fbfr_leg.sv */
// One bridge leg with crossover dead time between source and sink
`timescale 1ns/1ps
module fbfr_leg
  import fbfr_pkg::*;
#(
  parameter int unsigned DEAD_CNT = DEAD_CYCLES
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire fbfr_leg_type want_i,
  output fbfr_leg_type      leg_o
);

  initial begin
    if (DEAD_CNT < 1 || DEAD_CNT > 255) begin
      $error("fbfr_leg: DEAD_CNT out of range");
    end
  end

  fbfr_leg_type cur_reg, cur_next;
  logic [7:0]   dead_reg, dead_next;

  // ****************************************
  // Dead-time sequencer
  // ****************************************
  // Any change first drops both switches, then waits before turning one on
  always_comb begin
    cur_next  = cur_reg;
    dead_next = dead_reg;
    if (want_i != cur_reg) begin
      if (cur_reg.src || cur_reg.snk) begin
        cur_next  = '{1'b0, 1'b0};
        dead_next = DEAD_CNT[7:0];
      end else if (!(want_i.src || want_i.snk)) begin
        cur_next = want_i;
      end else if (dead_reg != 8'h00) begin
        dead_next = dead_reg - 8'h01;
      end else begin
        cur_next = want_i;
      end
    end else if (dead_reg != 8'h00) begin
      dead_next = dead_reg - 8'h01;
    end
  end

  // Registered so the gate commands are glitch free
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur_reg  <= '{1'b0, 1'b0};
      dead_reg <= DEAD_CNT[7:0];
    end else begin
      cur_reg  <= cur_next;
      dead_reg <= dead_next;
    end
  end

  assign leg_o = cur_reg;

endmodule
